// *** bench/wwdt_bench.sv ***
// Self-checking bench of the windowed watchdog beside a reset controller model.
// Assumes short divider parameters, so the counter steps once every eight clocks.

module wwdt_bench
	import wwdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
	} wwdt_row_t;

	logic              clk_i     = 1'b0;
	logic              bench_rst = 1'b1;
	logic              rst_i;
	logic              wr_i      = 1'b0;
	logic              rd_i      = 1'b0;
	logic              dbg       = 1'b1;
	logic              idle      = 1'b0;
	logic              honour    = 1'b0;
	logic [ADDR_W-1:0] addr      = 8'h00;
	logic [DATA_W-1:0] wdata     = 32'h0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] got;
	logic [DATA_W-1:0] keep;
	logic              irq;
	logic              fault;
	logic              proc_only;
	logic              reset_req;
	logic [1:0]        kind;
	int                err_count = 0;
	int                n_tests   = 0;
	int                i;
	int                k;

	wwdt_row_t rows [9] = '{
		'{1'b0, OFS_MODE, 32'h3FFF_2FFF},
		'{1'b0, OFS_STATUS, 32'h0},
		'{1'b0, OFS_IRQ_MASK, 32'h3},
		'{1'b0, OFS_COUNT, 32'h0FFF},
		'{1'b1, OFS_COUNT, 32'h0123},
		'{1'b0, OFS_COUNT, 32'h0FFF},
		'{1'b1, OFS_STATUS, 32'h3},
		'{1'b0, OFS_STATUS, 32'h0},
		'{1'b0, 8'h14, 32'h0}
	};

	always #25 clk_i = ~clk_i;
	assign rst_i = bench_rst | reset_req;

	wwdt_top #(
		.SLOW_DIV_P  (2),
		.PRESC_DIV_P (4)
	) wwdt_top_i (
		.clk_i             (clk_i),
		.rst_i             (rst_i),
		.addr_i            (addr),
		.wdata_i           (wdata),
		.wr_i              (wr_i),
		.rd_i              (rd_i),
		.rdata_o           (rdata),
		.debug_state_i     (dbg),
		.idle_mode_i       (idle),
		.irq_o             (irq),
		.fault_o           (fault),
		.fault_proc_only_o (proc_only)
	);

	wwdt_resetctl wwdt_resetctl_i (
		.clk_i       (clk_i),
		.fault_i     (fault),
		.proc_only_i (proc_only),
		.honour_i    (honour),
		.reset_o     (reset_req),
		.kind_o      (kind)
	);

	// ----------------------------------------------------------------
	// Bus cycles and checks
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr  <= a;
		wdata <= d;
		wr_i  <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 got = rdata;
	endtask : rd

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic do_reset;
		bench_rst <= 1'b1;
		cyc(5);
		bench_rst <= 1'b0;
		cyc(1);
	endtask : do_reset

	task automatic wait_fault;
		for (i = 0; i < 400 && fault !== 1'b1; i++) cyc(1);
		chk(fault, 32'h1);
	endtask : wait_fault

	task automatic give_verdict;
		$display("mismatches %0d, checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		for (k = 0; k < 9; k++) begin
			if (rows[k].w) wr(rows[k].a, rows[k].d);
			else begin
				rd(rows[k].a);
				chk(got, rows[k].d);
			end
		end
		dbg <= 1'b0;
		wr(OFS_MODE, 32'h3010_3020);
		rd(OFS_COUNT);
		chk(got, 32'h0020);
		rd(OFS_MODE);
		chk(got, 32'h3010_3020);
		wr(OFS_MODE, 32'h0000_8FFF);
		rd(OFS_MODE);
		chk(got, 32'h3010_3020);
		for (k = 0; k < 2; k++) begin
			{dbg, idle} <= (k == 0) ? 2'h1 : 2'h2;
			cyc(3);
			rd(OFS_COUNT);
			keep = got;
			cyc(40);
			rd(OFS_COUNT);
			chk(got, keep);
		end
		{dbg, idle} <= 2'h0;
		wr(OFS_CONTROL, 32'h5A00_0001);
		rd(OFS_STATUS);
		chk(got, 32'h0);
		wr(OFS_CONTROL, 32'hA500_0001);
		cyc(2);
		chk({irq, fault}, 2'h3);
		chk({proc_only, kind}, 3'h2);
		wr(OFS_IRQ_MASK, 32'h0);
		cyc(2);
		chk(irq, 1'h0);
		wr(OFS_IRQ_MASK, 32'h3);
		cyc(2);
		chk(irq, 1'h1);
		rd(OFS_STATUS);
		chk(got, 32'h2);
		cyc(1);
		chk({irq, fault}, 2'h0);
		// Wait until the counter has come down into the restart window.
		cyc(140);
		wr(OFS_CONTROL, 32'hA500_0001);
		rd(OFS_COUNT);
		chk(got, 32'h0020);
		rd(OFS_STATUS);
		chk(got, 32'h0);
		wait_fault();
		cyc(1);
		chk({irq, fault}, 2'h3);
		cyc(300);
		rd(OFS_STATUS);
		chk(got, 32'h1);
		honour <= 1'b1;
		wait_fault();
		cyc(6);
		honour <= 1'b0;
		rd(OFS_MODE);
		chk(got, 32'h3FFF_2FFF);
		chk(fault, 1'h0);
		do_reset();
		dbg <= 1'b1;
		wr(OFS_MODE, 32'h0000_6008);
		cyc(30);
		rd(OFS_COUNT);
		chk(got < 32'h8, 1'h1);
		wr(OFS_CONTROL, 32'hA500_0001);
		cyc(2);
		chk({irq, fault, proc_only, kind}, 5'h0D);
		dbg <= 1'b0;
		do_reset();
		wr(OFS_MODE, 32'h0000_8004);
		cyc(60);
		rd(OFS_COUNT);
		chk(got, 32'h4);
		wr(OFS_CONTROL, 32'hA500_0001);
		rd(OFS_STATUS);
		chk({got[1:0], fault}, 3'h4);
		give_verdict();
	end

	initial begin
		#500_000;
		err_count++;
		give_verdict();
	end

endmodule : wwdt_bench

// *** bench/wwdt_resetctl.sv ***
// Behavioural model of the reset controller that listens to the watchdog fault lines.
// Assumes the fault lines are registered outputs of the watchdog in the clk_i domain.

module wwdt_resetctl (
	input  wire logic       clk_i,
	input  wire logic       fault_i,
	input  wire logic       proc_only_i,
	input  wire logic       honour_i,
	output logic            reset_o,
	output logic      [1:0] kind_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Fault capture
	// ----------------------------------------------------------------
	logic [1:0] hold    = 2'h0;
	logic [1:0] kind    = 2'h0;
	logic       fault_q = 1'b0;

	// Kind 1 is a processor-only request, kind 2 a request for all resets.
	// When honoured, a fault pulls the processor reset for three cycles.
	always @(posedge clk_i) begin
		fault_q <= fault_i;
		if (fault_i && !fault_q) begin
			kind <= proc_only_i ? 2'h1 : 2'h2;
			hold <= honour_i ? 2'h3 : 2'h0;
		end else if (hold != 2'h0) begin
			hold <= hold - 2'h1;
		end
	end

	assign kind_o  = kind;
	assign reset_o = (hold != 2'h0);

endmodule : wwdt_resetctl

// *** verilog/wwdt_divider.sv ***
// Enable-driven divider that emits one-cycle tick pulses.
// Assumes clear and enable come from the same clock domain.

module wwdt_divider
	import wwdt_pkg::*;
#(
	parameter int unsigned DIV = PRESC_DIV
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic clear_i,
	input  wire logic enable_i,
	output logic      tick_o
);

	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic         next_tick;

	always_comb begin
		next_count = count;
		next_tick  = 1'b0;
		if (clear_i) begin
			next_count = '0;
		end else if (enable_i) begin
			if (count == W'(DIV - 1)) begin
				next_count = '0;
				next_tick  = 1'b1;
			end else begin
				next_count = count + W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count  <= '0;
			tick_o <= 1'b0;
		end else begin
			count  <= next_count;
			tick_o <= next_tick;
		end
	end

endmodule : wwdt_divider

// *** verilog/wwdt_pkg.sv ***
// Constants, field layout and helpers of the windowed watchdog timer.
// Assumes a single 20 MHz clock and a simple strobed register port.
//
// Summary of operation
// - Control writes are ignored entirely unless the key byte holds the key.
// - The reload value field is loaded into the 12-bit down counter.
// - Faults raise the interrupt only while the fault interrupt enable is one.
// - Faults request a watchdog reset only while the reset enable is one.
// - Processor-only select picks processor reset alone, otherwise all resets.
// - A keyed restart at counter not above delta reloads and restarts counter.
// - A keyed restart with counter above delta is a window error instead.
// - With debug halt set the counter stops during debug state.
// - With idle halt set the counter stops during idle mode.
// - The disable bit stops the counter when one; keyed restarts still check the window.
// - The underflow flag is sticky until the status register is read.
// - The window error flag is sticky until the status register is read.
// - The counter decrements on the slow clock divided by 128.
// - Mode accepts one write after reset, which reloads and restarts the counter.
// - An accepted restart reloads the counter and clears the 128 prescaler.
// - Status read or reset clears flags, interrupt and the fault signal.

package wwdt_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ    = 20_000_000;
	localparam int unsigned SLOW_HZ   = 32_768;
	localparam int unsigned SLOW_DIV  = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;
	localparam int unsigned PRESC_DIV = 128;
	localparam int unsigned CNT_W     = 12;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned DATA_W       = 32;
	localparam logic [7:0]  OFS_CONTROL  = 8'h00;
	localparam logic [7:0]  OFS_MODE     = 8'h04;
	localparam logic [7:0]  OFS_STATUS   = 8'h08;
	localparam logic [7:0]  OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0]  OFS_COUNT    = 8'h10;

	// ----------------------------------------------------------------
	// Fields
	// ----------------------------------------------------------------
	localparam int unsigned KEY_LSB      = 24;
	localparam logic [7:0]  KEY_VALUE    = 8'hA5;
	localparam int unsigned CTRL_RESTART = 0;
	localparam int unsigned MODE_RELOAD  = 0;
	localparam int unsigned MODE_IRQ_EN  = 12;
	localparam int unsigned MODE_RST_EN  = 13;
	localparam int unsigned MODE_PROC    = 14;
	localparam int unsigned MODE_DIS     = 15;
	localparam int unsigned MODE_DELTA   = 16;
	localparam int unsigned MODE_DBG     = 28;
	localparam int unsigned MODE_IDLE    = 29;
	localparam logic [31:0] MODE_MASK    = 32'h3FFF_FFFF;
	localparam logic [31:0] MODE_RESET   = 32'h3FFF_2FFF;
	localparam int unsigned STAT_UNF     = 0;
	localparam int unsigned STAT_ERR     = 1;
	localparam int unsigned STAT_W       = 2;
	localparam logic [1:0]  IRQ_MASK_RST = 2'h3;

	typedef enum logic [1:0] {
		WWDT_RUN  = 2'b00,
		WWDT_HALT = 2'b01,
		WWDT_OFF  = 2'b11
	} wwdt_state_t;

	function automatic logic wwdt_hit(input logic [7:0] addr, input logic [7:0] ofs);
		wwdt_hit = (addr == ofs);
	endfunction : wwdt_hit

endpackage : wwdt_pkg

// *** verilog/wwdt_top.sv ***
// Windowed watchdog timer: register port, counter, flags and fault outputs.
// Assumes rst_i is the processor reset and all inputs are synchronous to clk_i.

module wwdt_top
	import wwdt_pkg::*;
#(
	parameter int unsigned SLOW_DIV_P  = SLOW_DIV,
	parameter int unsigned PRESC_DIV_P = PRESC_DIV
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	input  wire logic              debug_state_i,
	input  wire logic              idle_mode_i,
	output logic                   irq_o,
	output logic                   fault_o,
	output logic                   fault_proc_only_o
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [31:0]       mode;
	logic              mode_written;
	logic [CNT_W-1:0]  count;
	wwdt_state_t       cnt_state;
	logic [STAT_W-1:0] status;
	logic [STAT_W-1:0] irq_mask;
	logic              slow_tick;
	logic              presc_tick;

	logic [CNT_W-1:0] reload;
	logic [CNT_W-1:0] delta;
	logic             ctrl_wr;
	logic             mode_wr;
	logic             mask_wr;
	logic             stat_rd;
	logic             key_ok;
	logic             restart_cmd;
	logic             restart_ok;
	logic             win_err;
	logic             mode_accept;
	logic             running;
	logic             underflow;

	assign reload      = mode[MODE_RELOAD +: CNT_W];
	assign delta       = mode[MODE_DELTA +: CNT_W];
	assign ctrl_wr     = wr_i && wwdt_hit(addr_i, OFS_CONTROL);
	assign mode_wr     = wr_i && wwdt_hit(addr_i, OFS_MODE);
	assign mask_wr     = wr_i && wwdt_hit(addr_i, OFS_IRQ_MASK);
	assign stat_rd     = rd_i && wwdt_hit(addr_i, OFS_STATUS);
	assign key_ok      = (wdata_i[KEY_LSB +: 8] == KEY_VALUE);
	assign restart_cmd = ctrl_wr && key_ok && wdata_i[CTRL_RESTART];
	assign restart_ok  = restart_cmd && (count <= delta);
	assign win_err     = restart_cmd && (count > delta);
	assign mode_accept = mode_wr && !mode_written;
	assign running     = (cnt_state == WWDT_RUN);
	assign underflow   = running && presc_tick && (count == {CNT_W{1'b0}});

	// ----------------------------------------------------------------
	// Clock dividers
	// ----------------------------------------------------------------
	wwdt_divider #(
		.DIV (SLOW_DIV_P)
	) u_slow_div (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clear_i  (1'b0),
		.enable_i (1'b1),
		.tick_o   (slow_tick)
	);

	// The prescaler pauses with the counter so a halt does not shorten a period.
	wwdt_divider #(
		.DIV (PRESC_DIV_P)
	) u_presc_div (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clear_i  (restart_ok || mode_accept),
		.enable_i (slow_tick && running),
		.tick_o   (presc_tick)
	);

	// ----------------------------------------------------------------
	// Mode register
	// ----------------------------------------------------------------
	logic [31:0] next_mode;
	logic        next_mode_written;

	always_comb begin
		next_mode         = mode;
		next_mode_written = mode_written;
		if (mode_accept) begin
			next_mode         = wdata_i & MODE_MASK;
			next_mode_written = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode         <= MODE_RESET;
			mode_written <= 1'b0;
		end else begin
			mode         <= next_mode;
			mode_written <= next_mode_written;
		end
	end

	// ----------------------------------------------------------------
	// Counter and run state
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] next_count;
	wwdt_state_t      next_state;

	always_comb begin
		next_count = count;
		if (mode_accept) begin
			next_count = wdata_i[MODE_RELOAD +: CNT_W];
		end else if (restart_ok || underflow) begin
			next_count = reload;
		end else if (running && presc_tick) begin
			next_count = count - CNT_W'(1);
		end
	end

	always_comb begin
		case (cnt_state)
			WWDT_RUN, WWDT_HALT, WWDT_OFF: begin
				if (mode[MODE_DIS]) begin
					next_state = WWDT_OFF;
				end else if (mode[MODE_DBG] && debug_state_i) begin
					next_state = WWDT_HALT;
				end else if (mode[MODE_IDLE] && idle_mode_i) begin
					next_state = WWDT_HALT;
				end else begin
					next_state = WWDT_RUN;
				end
			end
			default: begin
				next_state = WWDT_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count     <= {CNT_W{1'b1}};
			cnt_state <= WWDT_RUN;
		end else begin
			count     <= next_count;
			cnt_state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Status, interrupt, fault and read data
	// ----------------------------------------------------------------
	logic [STAT_W-1:0] next_status;
	logic [STAT_W-1:0] next_mask;
	logic              next_irq;
	logic              next_fault;
	logic              next_fault_proc;
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		next_status = status;
		next_fault  = fault_o;
		if (stat_rd) begin
			next_status = '0;
			next_fault  = 1'b0;
		end
		if (underflow) begin
			next_status[STAT_UNF] = 1'b1;
		end
		if (win_err) begin
			next_status[STAT_ERR] = 1'b1;
		end
		if ((underflow || win_err) && mode[MODE_RST_EN]) begin
			next_fault = 1'b1;
		end
		next_mask       = mask_wr ? wdata_i[STAT_W-1:0] : irq_mask;
		next_irq        = mode[MODE_IRQ_EN] && |(next_status & irq_mask);
		next_fault_proc = next_fault && mode[MODE_PROC];
	end

	always_comb begin
		next_rdata = '0;
		if (rd_i) begin
			case (addr_i)
				OFS_MODE:     next_rdata = mode;
				OFS_STATUS:   next_rdata = {{(DATA_W - STAT_W){1'b0}}, status};
				OFS_IRQ_MASK: next_rdata = {{(DATA_W - STAT_W){1'b0}}, irq_mask};
				OFS_COUNT:    next_rdata = {{(DATA_W - CNT_W){1'b0}}, count};
				default:      next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status            <= '0;
			irq_mask          <= IRQ_MASK_RST;
			irq_o             <= 1'b0;
			fault_o           <= 1'b0;
			fault_proc_only_o <= 1'b0;
			rdata_o           <= '0;
		end else begin
			status            <= next_status;
			irq_mask          <= next_mask;
			irq_o             <= next_irq;
			fault_o           <= next_fault;
			fault_proc_only_o <= next_fault_proc;
			rdata_o           <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	key_guard_a: assert property (
		ctrl_wr && !key_ok |=> count == $past(count) || $past(presc_tick))
		else $error("Unkeyed control write changed the counter.");

	restart_load_a: assert property (
		restart_ok |=> count == $past(reload) ##1 count == $past(reload, 2))
		else $error("Accepted restart did not reload the counter.");

	window_err_a: assert property (
		win_err |=> status[STAT_ERR] &&
			(count == $past(count) || count == $past(count) - CNT_W'(1)))
		else $error("Early restart not flagged as window error.");

	irq_gate_a: assert property (
		irq_o |-> $past(mode[MODE_IRQ_EN]) && |$past(next_status))
		else $error("Interrupt raised while fault interrupt disabled.");

	fault_gate_a: assert property (
		$rose(fault_o) |-> $past(mode[MODE_RST_EN]) && $past(underflow || win_err))
		else $error("Fault raised without reset enable and event.");

	fault_scope_a: assert property (
		fault_proc_only_o |-> fault_o && $past(mode[MODE_PROC]))
		else $error("Processor-only fault scope inconsistent.");

	debug_halt_a: assert property (
		mode[MODE_DBG] && debug_state_i |=> cnt_state != WWDT_RUN)
		else $error("Counter running during debug with halt set.");

	idle_halt_a: assert property (
		mode[MODE_IDLE] && idle_mode_i |=> cnt_state != WWDT_RUN)
		else $error("Counter running during idle with halt set.");

	disable_off_a: assert property (
		mode[MODE_DIS] |=> cnt_state == WWDT_OFF ##0 !underflow)
		else $error("Disabled watchdog still counting.");

	unf_sticky_a: assert property (
		status[STAT_UNF] && !stat_rd |=> status[STAT_UNF])
		else $error("Underflow flag dropped without status read.");

	err_sticky_a: assert property (
		status[STAT_ERR] && !stat_rd |=> status[STAT_ERR])
		else $error("Error flag dropped without status read.");

	count_step_a: assert property (
		!$past(restart_ok || mode_accept || underflow) && count != $past(count)
			|-> count == $past(count) - CNT_W'(1) && $past(presc_tick))
		else $error("Counter moved without a prescaler tick.");

	mode_once_a: assert property (
		mode_written && mode_wr |=> mode == $past(mode))
		else $error("Mode register accepted a second write.");

	presc_clear_a: assert property (
		restart_ok |=> !presc_tick)
		else $error("Prescaler not cleared by restart.");

	read_clear_a: assert property (
		stat_rd && !underflow && !win_err |=> status == '0 && !fault_o && !irq_o)
		else $error("Status read did not clear flags and outputs.");

	irq_off_a: assert property (
		!mode[MODE_IRQ_EN] |=> !irq_o)
		else $error("Fault reached the interrupt with its enable clear.");

	reset_off_a: assert property (
		!mode[MODE_RST_EN] && !fault_o |=> !fault_o)
		else $error("Fault signal raised with reset enable clear.");

	all_scope_a: assert property (
		fault_o && !fault_proc_only_o |-> !$past(mode[MODE_PROC]))
		else $error("All-reset scope shown with processor-only select set.");

	unf_reload_a: assert property (
		underflow && !mode_accept |=> count == $past(reload) && status[STAT_UNF])
		else $error("Underflow did not reload the counter and set its flag.");

	restart_c: cover property (restart_ok ##1 count == reload);
	window_c: cover property (win_err ##1 status[STAT_ERR]);
	underflow_c: cover property (underflow ##1 fault_o);
	read_clear_c: cover property (status != '0 ##0 stat_rd ##1 status == '0);
	halt_c: cover property (cnt_state == WWDT_HALT ##1 cnt_state == WWDT_RUN);

endmodule : wwdt_top
